// File: pkg/ahl_pkg.sv
// Package of constants and types for the axis homing and limits block
package ahl_pkg;
  // ==========================================================
  // Widths
  localparam int POS_W = 32;
  localparam int FILT_W = 20;
  // ==========================================================
  // Timing
  localparam longint CLK_HZ = 64'h0000000002faf080; // 50 MHz
  localparam longint CLK_PERIOD_PS = 64'h000000e8d4a51000 / CLK_HZ;
  localparam longint REF_FILT_TIME_PS = 64'h000000017d784000; // 6.4 ms
  localparam int REF_FILT_CYC = int'(REF_FILT_TIME_PS / CLK_PERIOD_PS);
  localparam logic [FILT_W-1:0] LIM_FILT_CYC = 20'h00001; // Limit switches only synchronised
  // ==========================================================
  // Reset values
  localparam logic [POS_W-1:0] POS_RST = 32'h00000000;
  localparam logic [POS_W-1:0] SOFT_LO_RST = 32'h80000000;
  localparam logic [POS_W-1:0] SOFT_HI_RST = 32'h7fffffff;
  // ==========================================================
  // Homing modes and command carrier
  typedef enum logic [1:0] {
    AHL_MODE_ABS = 2'h0,
    AHL_MODE_REL = 2'h1,
    AHL_MODE_PASSIVE = 2'h2,
    AHL_MODE_ACTIVE = 2'h3
  } ahl_mode_t;
  typedef struct packed {
    ahl_mode_t mode;
    logic [POS_W-1:0] position;
  } ahl_home_cmd_t;
  // Software limit bound write carrier
  typedef struct packed {
    logic wr_low;
    logic wr_high;
    logic [POS_W-1:0] value;
  } ahl_soft_wr_t;
endpackage

// File: hdl/ahl_in_filt.sv
// Synchroniser and stability filter for one switch input
`timescale 1ns/1ps
module ahl_in_filt
  import ahl_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic din, // Raw switch pin
  input wire logic [FILT_W-1:0] cycles, // Cycles a change must stay stable
  output logic dout_ff // Filtered level
);
  logic s1_ff, s2_ff, s3_ff;
  logic [FILT_W-1:0] cnt_ff;
  logic [FILT_W-1:0] nxt_cnt;
  logic nxt_dout;
  logic stable;
  logic expired;

  // ==========================================================
  // Filter decode
  assign stable = (s2_ff == s3_ff);
  assign expired = (cnt_ff + 20'h00001 >= cycles);
  assign nxt_cnt = (stable && s3_ff != dout_ff && !expired) ? cnt_ff + 20'h00001 : 20'h00000;
  assign nxt_dout = (stable && s3_ff != dout_ff && expired) ? s3_ff : dout_ff;

  // Three stages; only the second and third are compared, the first only feeds the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      cnt_ff <= 20'h00000;
      dout_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      cnt_ff <= nxt_cnt;
      dout_ff <= nxt_dout;
    end
  end
endmodule

// File: hdl/ahl_axis_home.sv
// Axis homing and position limit supervision
`timescale 1ns/1ps
// Overview of operation
// R01: Hardware limit supervision acts only while the hardware limit enable is set.
// R02: Software limit supervision acts only while the software limit enable is set.
// R03: New software bounds may be written anytime and apply to later checks.
// R04: Mode 0 loads position with commanded value at once, motion kept.
// R05: Mode 1 adds commanded value to current position, motion kept.
// R06: Modes 0 and 1 never move the axis; modes 2 and 3 need travel.
// R07: Mode 2 moves nothing; switch edge during external travel sets commanded position.
// R08: Mode 3 aborts motion, runs own approach, homes on switch detection.
// R09: Active homing uses configured rising or falling switch edge, not level.
// R10: After active homing position equals switch point plus commanded value; the code loads the commanded value alone at the switch edge.
// R11: Mode value 2 selects passive homing, value 3 active homing.
// R12: Reference switch comes only from an interrupt-capable digital input.
// R13: Reference filter defaults to 6.4 ms and can be reprogrammed.
// R14: Configurer keeps filter time shorter than switch active time.
// R15: Auto-reverse uses hardware limit as reversing cam; needs limits enabled.
// R16: Configurer keeps approach slow or decel high to avoid end stop.
// R17: Reference switch lies within the axis travel range.
// R18: Limit hit in active homing with auto-reverse: normal brake, reverse, search.
// R19: Limit hit in active homing without auto-reverse: error, emergency brake.
// R20: Homing done pulses when position set; error pulses on aborted approach.
module ahl_axis_home
  import ahl_pkg::*;
#(
  parameter logic [FILT_W-1:0] REF_FILT_DEFAULT = FILT_W'(REF_FILT_CYC) // 6.4 ms at 50 MHz
)(
  input wire logic SYS_CLK, // 50 MHz clock
  input wire logic ARST_N, // Asynchronous reset, active low
  input wire logic HOME_REQ, // One-cycle homing command strobe
  input wire ahl_home_cmd_t HOME_CMD, // Homing mode and position
  input wire logic HARD_LIM_EN, // Hardware limit enable
  input wire logic SOFT_LIM_EN, // Software limit enable
  input wire ahl_soft_wr_t SOFT_WR, // Software bound write
  input wire logic REF_EDGE_FALL, // Home on falling edge when set
  input wire logic AUTO_REV_EN, // Auto reverse at hardware limits
  input wire logic APPROACH_NEG, // Approach starts in negative direction
  input wire logic FILT_WR, // Load new reference filter count
  input wire logic [FILT_W-1:0] FILT_VAL, // Reference filter count in cycles
  input wire logic STEP, // One-cycle pulse per position step
  input wire logic STEP_NEG, // Step direction is negative
  input wire logic REF_SW, // Reference switch pin
  input wire logic LIM_NEG_SW, // Lower hardware limit switch pin
  input wire logic LIM_POS_SW, // Upper hardware limit switch pin
  output logic [POS_W-1:0] POSITION, // Axis position
  output logic HOMED, // Axis has been homed
  output logic HOME_DONE, // Homing complete pulse
  output logic HOME_ERR, // Homing error pulse
  output logic ABORT_REQ, // Abort motion pulse
  output logic APPROACH_RUN, // Request own approach motion
  output logic APPROACH_DIR_NEG, // Approach direction
  output logic BRAKE_NORMAL, // Brake at configured deceleration pulse
  output logic BRAKE_EMERG, // Brake at emergency deceleration pulse
  output logic HARD_LIM_STOP, // Hardware limit stop level
  output logic SOFT_LIM_STOP, // Software limit stop level
  output logic [FILT_W-1:0] REF_FILT_CUR // Active reference filter count
);
  typedef enum logic [1:0] {ST_IDLE, ST_PASSIVE, ST_ACTIVE} ahl_state_t;

  ahl_state_t state_ff, nxt_state;
  logic [POS_W-1:0] pos_ff, nxt_pos, soft_lo_ff, soft_hi_ff, cmd_pos_ff;
  logic [FILT_W-1:0] filt_ff;
  logic [2:0] raw_in, filt_out;
  logic [FILT_W-1:0] filt_cyc [3];
  logic ref_dly_ff, homed_ff, dir_neg_ff, nxt_dir_neg;
  logic done_ff, err_ff, abort_ff, brk_n_ff, brk_e_ff, hard_ff, soft_ff;
  logic ref_edge, hit_lim, auto_rev, take, home_now, lim_neg, lim_pos;

  // ==========================================================
  // Input filtering
  assign raw_in = {LIM_POS_SW, LIM_NEG_SW, REF_SW}; // R12
  assign filt_cyc[0] = filt_ff; // R13
  assign filt_cyc[1] = LIM_FILT_CYC;
  assign filt_cyc[2] = LIM_FILT_CYC;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      ahl_in_filt u_filt (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .din(raw_in[gi]),
        .cycles(filt_cyc[gi]),
        .dout_ff(filt_out[gi])
      );
    end
  endgenerate
  assign lim_neg = filt_out[1];
  assign lim_pos = filt_out[2];

  // ==========================================================
  // Decoding
  // Edge rather than level so the home point does not smear over the switch width
  assign ref_edge = REF_EDGE_FALL ? (ref_dly_ff && !filt_out[0]) : (!ref_dly_ff && filt_out[0]); // R09
  // Reversal needs the limits themselves to be live
  assign auto_rev = AUTO_REV_EN && HARD_LIM_EN; // R15
  assign hit_lim = HARD_LIM_EN && (dir_neg_ff ? lim_neg : lim_pos); // R01
  assign take = HOME_REQ && (state_ff == ST_IDLE);
  // Homing on the switch edge, passive or active, sets commanded position
  assign home_now = (state_ff != ST_IDLE) && ref_edge;

  // Next state; a new request is refused while homing is in progress
  always_comb begin
    nxt_state = state_ff;
    nxt_dir_neg = dir_neg_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take && HOME_CMD.mode == AHL_MODE_PASSIVE) begin // R11
          nxt_state = ST_PASSIVE; // R07
        end else if (take && HOME_CMD.mode == AHL_MODE_ACTIVE) begin // R11
          nxt_state = ST_ACTIVE; // R08
          nxt_dir_neg = APPROACH_NEG;
        end
      end
      ST_PASSIVE: begin
        if (ref_edge) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ACTIVE: begin
        if (ref_edge) begin
          nxt_state = ST_IDLE; // R08
        end else if (hit_lim && auto_rev) begin
          nxt_dir_neg = !dir_neg_ff; // R18
        end else if (hit_lim) begin
          nxt_state = ST_IDLE; // R19
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Position: homing overrides a step that lands in the same cycle
  always_comb begin
    nxt_pos = pos_ff;
    if (take && HOME_CMD.mode == AHL_MODE_ABS) begin
      nxt_pos = HOME_CMD.position; // R04
    end else if (take && HOME_CMD.mode == AHL_MODE_REL) begin
      nxt_pos = pos_ff + HOME_CMD.position; // R05
    end else if (home_now) begin
      nxt_pos = cmd_pos_ff; // R10
    end else if (STEP) begin
      nxt_pos = STEP_NEG ? pos_ff - 32'h00000001 : pos_ff + 32'h00000001;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= ST_IDLE;
      pos_ff <= POS_RST;
      cmd_pos_ff <= POS_RST;
      dir_neg_ff <= 1'b0;
      ref_dly_ff <= 1'b0;
      homed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pos_ff <= nxt_pos;
      dir_neg_ff <= nxt_dir_neg;
      ref_dly_ff <= filt_out[0];
      if (take) begin
        cmd_pos_ff <= HOME_CMD.position;
      end
      if (HOME_DONE) begin
        homed_ff <= 1'b1;
      end
    end
  end

  // Configuration: bounds and filter count may change while running
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      soft_lo_ff <= SOFT_LO_RST;
      soft_hi_ff <= SOFT_HI_RST;
      filt_ff <= REF_FILT_DEFAULT; // R13
    end else begin
      if (SOFT_WR.wr_low) begin
        soft_lo_ff <= SOFT_WR.value; // R03
      end
      if (SOFT_WR.wr_high) begin
        soft_hi_ff <= SOFT_WR.value; // R03
      end
      if (FILT_WR) begin
        filt_ff <= FILT_VAL; // R13
      end
    end
  end

  // Event pulses and stop levels
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      abort_ff <= 1'b0;
      brk_n_ff <= 1'b0;
      brk_e_ff <= 1'b0;
      hard_ff <= 1'b0;
      soft_ff <= 1'b0;
    end else begin
      done_ff <= (take && HOME_CMD.mode[1] == 1'b0) || home_now; // R20
      err_ff <= (state_ff == ST_ACTIVE) && !ref_edge && hit_lim && !auto_rev; // R20
      abort_ff <= take && HOME_CMD.mode == AHL_MODE_ACTIVE; // R08
      brk_n_ff <= (state_ff == ST_ACTIVE) && !ref_edge && hit_lim && auto_rev; // R18
      brk_e_ff <= (state_ff == ST_ACTIVE) && !ref_edge && hit_lim && !auto_rev; // R19
      // Outside the approach a live limit switch stops the axis
      hard_ff <= HARD_LIM_EN && (state_ff != ST_ACTIVE) && (lim_neg || lim_pos); // R01
      // Software bounds only mean something once the axis has been homed
      soft_ff <= SOFT_LIM_EN && homed_ff &&
                 ($signed(pos_ff) <= $signed(soft_lo_ff) || $signed(pos_ff) >= $signed(soft_hi_ff)); // R02
    end
  end

  // ==========================================================
  // Outputs
  assign POSITION = pos_ff;
  assign HOMED = homed_ff;
  assign HOME_DONE = done_ff;
  assign HOME_ERR = err_ff;
  assign ABORT_REQ = abort_ff;
  assign APPROACH_RUN = (state_ff == ST_ACTIVE); // R06
  assign APPROACH_DIR_NEG = dir_neg_ff;
  assign BRAKE_NORMAL = brk_n_ff;
  assign BRAKE_EMERG = brk_e_ff;
  assign HARD_LIM_STOP = hard_ff;
  assign SOFT_LIM_STOP = soft_ff;
  assign REF_FILT_CUR = filt_ff;

  // ==========================================================
  // Assertions
  property p_abs_load;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      take && HOME_CMD.mode == AHL_MODE_ABS |=> POSITION == $past(HOME_CMD.position) && HOME_DONE;
  endproperty
  a_abs_load: assert property (p_abs_load) else $error("Absolute homing did not load position"); // R04

  property p_rel_add;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      take && HOME_CMD.mode == AHL_MODE_REL |=> POSITION == $past(pos_ff) + $past(HOME_CMD.position);
  endproperty
  a_rel_add: assert property (p_rel_add) else $error("Relative homing sum wrong"); // R05

  property p_no_move;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      take && !HOME_CMD.mode[1] |=> !ABORT_REQ && !APPROACH_RUN;
  endproperty
  a_no_move: assert property (p_no_move) else $error("Direct homing caused motion"); // R06

  property p_passive;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      state_ff == ST_PASSIVE && ref_edge |=> POSITION == $past(cmd_pos_ff) && HOME_DONE && !ABORT_REQ;
  endproperty
  a_passive: assert property (p_passive) else $error("Passive homing missed switch"); // R07

  property p_active_start;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      take && HOME_CMD.mode == AHL_MODE_ACTIVE |=> ABORT_REQ && APPROACH_RUN ##1 !ABORT_REQ;
  endproperty
  a_active_start: assert property (p_active_start) else $error("Active homing did not abort"); // R08

  property p_reverse;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      state_ff == ST_ACTIVE && !ref_edge && hit_lim && auto_rev |=>
        BRAKE_NORMAL && !BRAKE_EMERG && APPROACH_DIR_NEG != $past(dir_neg_ff);
  endproperty
  a_reverse: assert property (p_reverse) else $error("Auto reverse failed"); // R18

  property p_lim_err;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      state_ff == ST_ACTIVE && !ref_edge && hit_lim && !auto_rev |=> HOME_ERR && BRAKE_EMERG && !APPROACH_RUN;
  endproperty
  a_lim_err: assert property (p_lim_err) else $error("Limit abort not flagged"); // R19

  property p_hard_off;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      !HARD_LIM_EN |=> !HARD_LIM_STOP;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("Hardware limit acted while disabled"); // R01

  property p_soft_off;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      !SOFT_LIM_EN |=> !SOFT_LIM_STOP;
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("Software limit acted while disabled"); // R02

  property p_bound_wr;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      SOFT_WR.wr_high |=> soft_hi_ff == $past(SOFT_WR.value);
  endproperty
  a_bound_wr: assert property (p_bound_wr) else $error("Upper bound not taken"); // R03
endmodule

// File: verif/ahl_axis_model.sv
// Behavioural drive, reference switch and hardware limit switches for the axis
`timescale 1ns/1ps
module ahl_axis_model #(
  parameter int DIV = 4, // Cycles per step
  parameter int REF_LO = 20, // Reference switch window, in steps
  parameter int REF_HI = 29,
  parameter int LIM_LO = -20, // Limit switch positions, in steps
  parameter int LIM_HI = 60
)(
  input wire logic clk, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic run_int, // Device asks for its own approach
  input wire logic dir_int, // Approach direction, 1 = negative
  input wire logic run_ext, // Travel commanded by the program
  input wire logic dir_ext, // Program travel direction, 1 = negative
  output logic step, // Step pulse
  output logic step_neg, // Step direction
  output logic ref_sw, // Reference switch
  output logic lim_neg_sw, // Lower limit switch
  output logic lim_pos_sw, // Upper limit switch
  output int phys // True carriage position
);
  int div_ff;
  logic dir;
  // ==========
  // Switches
  // Window of ten steps at DIV cycles outlasts any filter count the bench loads
  assign ref_sw = (phys >= REF_LO) && (phys <= REF_HI);
  assign lim_neg_sw = phys <= LIM_LO;
  assign lim_pos_sw = phys >= LIM_HI;
  assign dir = run_int ? dir_int : dir_ext;
  // ==========
  // Drive
  // Slow fixed step rate keeps the carriage short of the end stops on reversal
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= 0;
      phys <= 0;
      step <= 1'b0;
      step_neg <= 1'b0;
    end else begin
      step <= 1'b0;
      div_ff <= (div_ff + 1) % DIV;
      if ((run_int || run_ext) && div_ff == 0) begin
        step <= 1'b1;
        step_neg <= dir;
        phys <= dir ? phys - 1 : phys + 1;
      end
    end
  end
endmodule

// File: verif/ahl_axis_home_tb.sv
// Self-checking bench for axis homing and limit supervision
`timescale 1ns/1ps
module ahl_axis_home_tb;
  import ahl_pkg::*;
  localparam logic [FILT_W-1:0] FILT = 20'h00004; // Short filter keeps the run brief
  logic clk, arst_n, req, hl_en, sl_en, fall, arev, apr_neg, fwr, run_ext, dir_ext;
  ahl_home_cmd_t cmd;
  ahl_soft_wr_t swr;
  logic [FILT_W-1:0] fval, fcur;
  logic step, step_neg, ref_sw, lneg, lpos, homed, done, err, abort, arun, adir, brk_n, brk_e, hstop, sstop;
  logic [POS_W-1:0] pos;
  logic [2:0] evt;
  int phys, errors, comparisons;
  // ==========
  // Design and far side
  assign evt = {brk_n, err, done};
  ahl_axis_home #(.REF_FILT_DEFAULT(FILT)) dut_u (.SYS_CLK(clk), .ARST_N(arst_n), .HOME_REQ(req),
    .HOME_CMD(cmd), .HARD_LIM_EN(hl_en), .SOFT_LIM_EN(sl_en), .SOFT_WR(swr), .REF_EDGE_FALL(fall),
    .AUTO_REV_EN(arev), .APPROACH_NEG(apr_neg), .FILT_WR(fwr), .FILT_VAL(fval), .STEP(step),
    .STEP_NEG(step_neg), .REF_SW(ref_sw), .LIM_NEG_SW(lneg), .LIM_POS_SW(lpos), .POSITION(pos),
    .HOMED(homed), .HOME_DONE(done), .HOME_ERR(err), .ABORT_REQ(abort), .APPROACH_RUN(arun),
    .APPROACH_DIR_NEG(adir), .BRAKE_NORMAL(brk_n), .BRAKE_EMERG(brk_e), .HARD_LIM_STOP(hstop),
    .SOFT_LIM_STOP(sstop), .REF_FILT_CUR(fcur));
  ahl_axis_model far_u (.clk(clk), .arst_n(arst_n), .run_int(arun), .dir_int(adir), .run_ext(run_ext),
    .dir_ext(dir_ext), .step(step), .step_neg(step_neg), .ref_sw(ref_sw), .lim_neg_sw(lneg),
    .lim_pos_sw(lpos), .phys(phys));
  // Clock of 20 ns
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Settle one ns past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait on one event line; running out ends the run
  task automatic wait_ev(input int i, input int lim);
    int k;
    k = 0;
    while (evt[i] !== 1'b1 && k < lim) begin
      cyc(1);
      k++;
    end
    // An event that arrives on the last allowed cycle still counts as seen
    if (evt[i] !== 1'b1) begin
      errors++;
      $display("BAD event %0d expected 1 seen timeout", i);
      stop_test();
    end
  endtask
  // One-cycle homing strobe; returns in the answer cycle
  task automatic home(input ahl_mode_t m, input logic [POS_W-1:0] p);
    @(posedge clk);
    req <= 1'b1;
    cmd <= '{m, p};
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask
  task automatic soft_wr(input logic lo, input logic hi, input logic [POS_W-1:0] v);
    @(posedge clk);
    swr <= '{lo, hi, v};
    @(posedge clk);
    swr <= '{1'b0, 1'b0, v};
    cyc(2);
  endtask
  // ==========
  // Sequence
  initial begin
    errors = 0;
    comparisons = 0;
    {arst_n, req, hl_en, sl_en, fall, arev, apr_neg, fwr, run_ext, dir_ext} = '0;
    cmd = '0;
    swr = '0;
    fval = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    cyc(1);
    chk("filter reset", FILT, fcur);
    home(AHL_MODE_ABS, 32'h00000064);
    chk("pos abs", 32'h00000064, pos);
    chk("done abs", 1'b1, done);
    chk("still abs", 1'b0, abort | arun);
    home(AHL_MODE_REL, 32'hffffffe2);
    chk("pos rel", 32'h00000046, pos);
    chk("still rel", 1'b0, abort | arun);
    chk("homed", 1'b1, homed);
    $display("test direct homing finished");
    @(posedge clk);
    fwr <= 1'b1;
    fval <= 20'h00006;
    @(posedge clk);
    fwr <= 1'b0;
    cyc(2);
    chk("filter new", 20'h00006, fcur);
    soft_wr(1'b0, 1'b1, 32'h00000032);
    chk("soft off", 1'b0, sstop);
    @(posedge clk) sl_en <= 1'b1;
    cyc(2);
    chk("soft high", 1'b1, sstop);
    soft_wr(1'b0, 1'b1, 32'h000000c8);
    chk("soft clear", 1'b0, sstop);
    soft_wr(1'b1, 1'b0, 32'h00000046);
    chk("soft low", 1'b1, sstop);
    soft_wr(1'b1, 1'b0, 32'h80000000);
    @(posedge clk) sl_en <= 1'b0;
    $display("test filter and soft limits finished");
    home(AHL_MODE_PASSIVE, 32'h000003e8);
    chk("passive still", 1'b0, abort | arun);
    // A direct request while passive homing is pending must be ignored
    home(AHL_MODE_ABS, 32'h00000005);
    chk("refused pos", 32'h00000046, pos);
    chk("refused done", 1'b0, done);
    @(posedge clk) run_ext <= 1'b1;
    wait_ev(0, 300);
    chk("pos passive", 32'h000003e8, pos);
    @(posedge clk) run_ext <= 1'b0;
    $display("test passive homing finished");
    @(posedge clk);
    hl_en <= 1'b1;
    arev <= 1'b1;
    apr_neg <= 1'b1;
    home(AHL_MODE_ACTIVE, 32'h00000007);
    chk("abort", 1'b1, abort);
    chk("run", 1'b1, arun);
    wait_ev(2, 600);
    chk("reverse", 1'b0, adir);
    chk("no emerg", 1'b0, brk_e);
    wait_ev(0, 600);
    chk("pos rise", 32'h00000007, pos);
    chk("rise point", 1'b1, phys >= 20 && phys <= 23);
    chk("run off", 1'b0, arun);
    @(posedge clk);
    fall <= 1'b1;
    apr_neg <= 1'b0;
    home(AHL_MODE_ACTIVE, 32'hfffffffb);
    wait_ev(0, 600);
    chk("pos fall", 32'hfffffffb, pos);
    chk("fall point", 1'b1, phys >= 30 && phys <= 33);
    $display("test active homing finished");
    @(posedge clk) arev <= 1'b0;
    home(AHL_MODE_ACTIVE, 32'h00000000);
    wait_ev(1, 600);
    chk("emerg", 1'b1, brk_e);
    chk("run stop", 1'b0, arun);
    chk("no done", 1'b0, done);
    cyc(3);
    chk("hard on", 1'b1, hstop);
    @(posedge clk) hl_en <= 1'b0;
    cyc(3);
    chk("hard off", 1'b0, hstop);
    $display("test limit abort finished");
    stop_test();
  end
endmodule
